/* File: rss_pkg.sv */
// Package for the rotate/halt/subtract execution block.
// Assumes a 14-bit instruction word and a four-phase instruction cycle.
package rss_pkg;

  // ****************************************
  // Instruction encodings
  // ****************************************
  localparam logic [13:0] RSS_HALT_WORD = 14'h0063;
  localparam logic [5:0] RSS_ROTL_TOP = 6'h0D;
  localparam logic [5:0] RSS_ROTR_TOP = 6'h0C;
  localparam logic [4:0] RSS_SUBK_TOP = 5'h1E;
  localparam int RSS_DEST_BIT = 7;
  localparam int RSS_SUBK_POS = 9;
  localparam int RSS_ROT_POS = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RSS_ACCUM_RST = 8'h00;
  localparam logic RSS_FLAG_RST = 1'b0;
  localparam logic RSS_NFLAG_RST = 1'b1;
  localparam logic [7:0] RSS_WDOG_ZERO = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {RSS_OP_NONE, RSS_OP_ROTL, RSS_OP_ROTR, RSS_OP_SUBK} rss_op_t;
  typedef enum {RSS_Q1, RSS_Q2, RSS_Q3, RSS_Q4} rss_phase_t;

endpackage

/* File: rss_decode.sv */
// Instruction decoder for the execution block.
// Assumes a stable instruction word for a whole instruction cycle.
`timescale 1ns/100ps
module rss_decode
  import rss_pkg::*;
(
  // Instruction
  input wire logic [13:0] instr,
  // Decoded
  output rss_op_t op,
  output logic is_halt,
  output logic to_accum
);

  always_comb begin
    op = RSS_OP_NONE;
    is_halt = (instr == RSS_HALT_WORD); // see (RL1)
    to_accum = ~instr[RSS_DEST_BIT];
    if (instr[13:RSS_SUBK_POS] == RSS_SUBK_TOP) begin
      op = RSS_OP_SUBK; // see (RL7)
      to_accum = 1'b1;
    end else if (instr[13:RSS_ROT_POS] == RSS_ROTL_TOP) begin
      op = RSS_OP_ROTL; // see (RL12)
    end else if (instr[13:RSS_ROT_POS] == RSS_ROTR_TOP) begin
      op = RSS_OP_ROTR; // see (RL13)
    end
  end

endmodule

/* File: rss_exec.sv */
// Execution unit for rotate through carry, halt and subtract from immediate.
// Assumes fetch presents instr with instr_valid at Q1; register file answers reads combinationally.
// Function
// (RL1) Halt word decoded, one word, one cycle
// (RL2) Halt touches only expiry and power-down flags
// (RL3) Halt clears power-down, sets expiry flag
// (RL4) Halt zeroes watchdog counter and prescaler
// (RL5) Halt enters low-power state, stops oscillator
// (RL6) Halt: decode, idle, idle, halt at Q4
// (RL7) Subtract decoded with don't-care bit, immediate byte
// (RL8) Immediate minus accumulator, two's complement
// (RL9) Subtract result always goes to accumulator
// (RL10) Subtract updates carry, half carry, zero
// (RL11) Carry set unless borrow occurs
// (RL12) Rotate left via carry, destination by bit
// (RL13) Rotate right via carry, carry only
`timescale 1ns/100ps
module rss_exec
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Instruction fetch
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  output logic phase_q1,
  // Register file
  output logic [6:0] rf_addr,
  input wire logic [7:0] rf_rdata,
  output logic [7:0] rf_wdata,
  output logic rf_we,
  // Wake from halt
  input wire logic wake_req,
  // Status and accumulator
  output logic [7:0] accumulator_reg,
  output logic borrow_inverse_bit,
  output logic half_borrow_inverse,
  output logic result_null_flag,
  output logic watchdog_expiry_flag_b,
  output logic power_down_flag_b,
  // Watchdog and oscillator
  output logic watchdog_clear,
  output logic osc_stop,
  output logic halted
);

  // ****************************************
  // Decode
  // ****************************************
  rss_op_t dec_op;
  logic dec_halt;
  logic dec_to_accum;
  logic [13:0] instr_reg, instr_next;

  // Write-back steering and its check share this test
  function automatic logic is_rotate(input rss_op_t op);
    is_rotate = (op == RSS_OP_ROTL) || (op == RSS_OP_ROTR);
  endfunction

  rss_decode u_dec (
    .instr(instr_reg),
    .op(dec_op),
    .is_halt(dec_halt),
    .to_accum(dec_to_accum)
  );

  // ****************************************
  // State
  // ****************************************
  rss_phase_t phase_reg, phase_next;
  logic active_reg, active_next;
  logic [7:0] opnd_reg, opnd_next;
  logic [7:0] res_reg, res_next;
  logic [7:0] acc_next;
  logic c_next, dc_next, z_next, to_next, pd_next;
  logic halt_reg, halt_next;
  logic wdc_reg, wdc_next;
  logic [7:0] rf_wdata_reg, rf_wdata_next;
  logic rf_we_reg, rf_we_next;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic wake_s1, wake_s2;

  // Wake arrives from outside the core clock domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else if (clk_en) begin
      wake_s1 <= wake_req;
      wake_s2 <= wake_s1;
    end
  end

  // One spare bit so the top of the difference is the borrow out
  always_comb begin
    diff = {1'b0, opnd_reg} - {1'b0, accumulator_reg}; // see (RL8)
    ndiff = {1'b0, opnd_reg[3:0]} - {1'b0, accumulator_reg[3:0]};
  end

  always_comb begin
    phase_next = phase_reg;
    instr_next = instr_reg;
    active_next = active_reg;
    opnd_next = opnd_reg;
    res_next = res_reg;
    acc_next = accumulator_reg;
    c_next = borrow_inverse_bit;
    dc_next = half_borrow_inverse;
    z_next = result_null_flag;
    to_next = watchdog_expiry_flag_b;
    pd_next = power_down_flag_b;
    halt_next = halt_reg;
    wdc_next = 1'b0;
    rf_wdata_next = rf_wdata_reg;
    rf_we_next = 1'b0;
    if (halt_reg) begin
      // Oscillator is stopped; only a wake restarts the phase sequence
      phase_next = RSS_Q1;
      active_next = 1'b0;
      if (wake_s2) begin
        halt_next = 1'b0;
      end
    end else begin
      case (phase_reg)
        RSS_Q1: begin
          instr_next = instr;
          active_next = instr_valid;
          phase_next = RSS_Q2;
        end
        RSS_Q2: begin
          // Halt only loads an unused register operand here
          if (dec_op == RSS_OP_SUBK) begin
            opnd_next = instr_reg[7:0]; // see (RL7)
          end else begin
            opnd_next = rf_rdata;
          end
          phase_next = RSS_Q3;
        end
        RSS_Q3: begin
          case (dec_op)
            RSS_OP_ROTL: res_next = {opnd_reg[6:0], borrow_inverse_bit}; // see (RL12)
            RSS_OP_ROTR: res_next = {borrow_inverse_bit, opnd_reg[7:1]}; // see (RL13)
            RSS_OP_SUBK: res_next = diff[7:0];
            default: res_next = res_reg;
          endcase
          phase_next = RSS_Q4;
        end
        RSS_Q4: begin
          phase_next = RSS_Q1;
          if (active_reg) begin
            if (dec_halt) begin
              // Arithmetic flags are left alone
              to_next = 1'b1; // see (RL2) (RL3)
              pd_next = 1'b0; // see (RL3)
              wdc_next = 1'b1; // see (RL4)
              halt_next = 1'b1; // see (RL5) (RL6)
            end else begin
              case (dec_op)
                RSS_OP_ROTL: begin
                  c_next = opnd_reg[7]; // see (RL12)
                end
                RSS_OP_ROTR: begin
                  c_next = opnd_reg[0]; // see (RL13)
                end
                RSS_OP_SUBK: begin
                  c_next = ~diff[8]; // see (RL10) (RL11)
                  dc_next = ~ndiff[4]; // see (RL10)
                  z_next = (res_reg == 8'h00); // see (RL10)
                  acc_next = res_reg; // see (RL9)
                end
                default: begin
                end
              endcase
              if (is_rotate(dec_op)) begin
                if (dec_to_accum) begin
                  acc_next = res_reg; // see (RL12)
                end else begin
                  rf_we_next = 1'b1;
                  rf_wdata_next = res_reg;
                end
              end
            end
          end
        end
        default: phase_next = RSS_Q1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= RSS_Q1;
      instr_reg <= 14'h0000;
      active_reg <= 1'b0;
      opnd_reg <= RSS_ACCUM_RST;
      res_reg <= RSS_ACCUM_RST;
      accumulator_reg <= RSS_ACCUM_RST;
      borrow_inverse_bit <= RSS_FLAG_RST;
      half_borrow_inverse <= RSS_FLAG_RST;
      result_null_flag <= RSS_FLAG_RST;
      watchdog_expiry_flag_b <= RSS_NFLAG_RST;
      power_down_flag_b <= RSS_NFLAG_RST;
      halt_reg <= 1'b0;
      wdc_reg <= 1'b0;
      rf_wdata_reg <= RSS_WDOG_ZERO;
      rf_we_reg <= 1'b0;
    end else if (clk_en) begin
      phase_reg <= phase_next;
      instr_reg <= instr_next;
      active_reg <= active_next;
      opnd_reg <= opnd_next;
      res_reg <= res_next;
      accumulator_reg <= acc_next;
      borrow_inverse_bit <= c_next;
      half_borrow_inverse <= dc_next;
      result_null_flag <= z_next;
      watchdog_expiry_flag_b <= to_next;
      power_down_flag_b <= pd_next;
      halt_reg <= halt_next;
      wdc_reg <= wdc_next;
      rf_wdata_reg <= rf_wdata_next;
      rf_we_reg <= rf_we_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign phase_q1 = (phase_reg == RSS_Q1) && !halt_reg;
  assign rf_addr = instr_reg[6:0];
  assign rf_wdata = rf_wdata_reg;
  assign rf_we = rf_we_reg;
  assign watchdog_clear = wdc_reg; // see (RL4)
  assign osc_stop = halt_reg; // see (RL5)
  assign halted = halt_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_HALT_FLAGS: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL3)
    $rose(halt_reg) |-> !power_down_flag_b && watchdog_expiry_flag_b && wdc_reg)
    else $error("halt did not set power flags");
  AST_HALT_ARITH: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL2)
    $rose(halt_reg) |-> $stable(borrow_inverse_bit) && $stable(result_null_flag) && $stable(accumulator_reg))
    else $error("halt changed arithmetic state");
  AST_HALT_Q4: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL6)
    $rose(halt_reg) |-> $past(phase_reg) == RSS_Q4)
    else $error("halt entered outside Q4");
  AST_OSC_STOP: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL5)
    halt_reg && !wake_s2 && clk_en |=> osc_stop)
    else $error("oscillator not held stopped");
  AST_SUB_ACC: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL9)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_SUBK && !dec_halt
      |=> accumulator_reg == $past(res_reg) && !rf_we)
    else $error("subtract result not in accumulator");
  AST_SUB_CARRY: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL11)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_SUBK && !dec_halt
      |=> borrow_inverse_bit == ($past(opnd_reg) >= $past(accumulator_reg)))
    else $error("carry wrong after subtract");
  AST_ROTL: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL12)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_ROTL && !dec_halt
      |=> borrow_inverse_bit == $past(opnd_reg[7]))
    else $error("rotate left carry wrong");
  AST_ROTR: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL13)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_ROTR && !dec_halt
      |=> borrow_inverse_bit == $past(opnd_reg[0]) && $stable(result_null_flag))
    else $error("rotate right carry wrong");
  // Antecedents need clk_en, so a frozen Q4 edge is not taken for a write-back
  AST_HALT_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL1)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_halt |=> halt_reg && !rf_we)
    else $error("halt word not taken in one cycle");
  AST_WDOG_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL4)
    wdc_reg && clk_en |=> !watchdog_clear)
    else $error("watchdog clear held too long");
  AST_HALT_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL5)
    halt_reg |=> $stable(accumulator_reg) && $stable(borrow_inverse_bit) && !rf_we)
    else $error("core state moved while halted");
  AST_SUB_HALF: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL10)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_SUBK && !dec_halt
      |=> half_borrow_inverse == ($past(opnd_reg[3:0]) >= $past(accumulator_reg[3:0])))
    else $error("half carry wrong after subtract");
  AST_SUB_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL10)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_SUBK && !dec_halt
      |=> result_null_flag == (accumulator_reg == 8'h00))
    else $error("zero flag wrong after subtract");
  AST_ROT_TO_REG: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL12)
    clk_en && phase_reg == RSS_Q4 && active_reg && is_rotate(dec_op) && !dec_to_accum
      |=> rf_we && rf_wdata == $past(res_reg) && $stable(accumulator_reg))
    else $error("rotate result not sent to register");
  AST_ROTL_DATA: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL12)
    clk_en && phase_reg == RSS_Q3 && active_reg && dec_op == RSS_OP_ROTL
      |=> res_reg == {$past(opnd_reg[6:0]), $past(borrow_inverse_bit)})
    else $error("rotate left data wrong");
  AST_ROTR_DATA: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL13)
    clk_en && phase_reg == RSS_Q3 && active_reg && dec_op == RSS_OP_ROTR
      |=> res_reg == {$past(borrow_inverse_bit), $past(opnd_reg[7:1])})
    else $error("rotate right data wrong");
  AST_NOP_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RL7)
    clk_en && phase_reg == RSS_Q4 && active_reg && dec_op == RSS_OP_NONE && !dec_halt
      |=> $stable(accumulator_reg) && $stable(borrow_inverse_bit) && $stable(result_null_flag) && !rf_we)
    else $error("unknown word changed state");

endmodule

/* File: rss_rf_model.sv */
// Register file model facing the execution block.
// Assumes reads are combinational and writes land on an enabled edge.
`timescale 1ns/100ps
module rss_rf_model (
  // Clock
  input wire logic sys_clk,
  input wire logic clk_en,
  // Core side
  input wire logic [6:0] rf_addr,
  output logic [7:0] rf_rdata,
  input wire logic [7:0] rf_wdata,
  input wire logic rf_we,
  // Bench preload
  input wire logic ld_en,
  input wire logic [6:0] ld_addr,
  input wire logic [7:0] ld_data
);
  // ****************************************
  // Storage
  // ****************************************
  // Unwritten places read unknown, so a stray read cannot pass for real data
  logic [7:0] mem [0:127];
  assign rf_rdata = mem[rf_addr];
  always_ff @(posedge sys_clk) begin
    if (clk_en && rf_we) begin
      mem[rf_addr] <= rf_wdata;
    end else if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end
endmodule

/* File: rotate_sleep_subtract_exec_bench.sv */
// Self-checking bench for the rotate, halt and subtract execution block.
// Assumes the register file model and a 40 MHz core clock.
`timescale 1ns/100ps
module rotate_sleep_subtract_exec_bench;
  import rss_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic instr_valid = 1'b0;
  logic wake_req = 1'b0;
  logic ld_en = 1'b0;
  logic [6:0] ld_addr = 7'h15;
  logic [7:0] ld_data = 8'hE6;
  logic phase_q1, rf_we, watchdog_clear, osc_stop, halted;
  logic borrow_inverse_bit, half_borrow_inverse, result_null_flag;
  logic watchdog_expiry_flag_b, power_down_flag_b;
  logic [6:0] rf_addr;
  logic [7:0] rf_rdata, rf_wdata, accumulator_reg, acc_m, rv;
  logic c_m, dc_m, z_m;
  int n_fail = 0;
  int n_compared = 0;

  rss_exec dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
    .phase_q1(phase_q1), .rf_addr(rf_addr), .rf_rdata(rf_rdata), .rf_wdata(rf_wdata), .rf_we(rf_we),
    .wake_req(wake_req), .accumulator_reg(accumulator_reg), .borrow_inverse_bit(borrow_inverse_bit),
    .half_borrow_inverse(half_borrow_inverse), .result_null_flag(result_null_flag),
    .watchdog_expiry_flag_b(watchdog_expiry_flag_b), .power_down_flag_b(power_down_flag_b),
    .watchdog_clear(watchdog_clear), .osc_stop(osc_stop), .halted(halted));
  rss_rf_model model (.sys_clk(sys_clk), .clk_en(clk_en), .rf_addr(rf_addr), .rf_rdata(rf_rdata),
    .rf_wdata(rf_wdata), .rf_we(rf_we), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task stop_test;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Issues one word at Q1 and returns in the cycle after the Q4 edge
  task exec(input logic [13:0] w, input int stall);
    int n;
    int s;
    n = 0;
    s = stall;
    for (int i = 0; i < 20 && phase_q1 !== 1'b1; i++) @(negedge sys_clk);
    chk1(phase_q1, 1'b1);
    instr = w;
    instr_valid = 1'b1;
    while (n < 4) begin
      @(posedge sys_clk);
      if (clk_en) n++;
      @(negedge sys_clk);
      if (n < 4) chk1(halted, 1'b0);
      if (n == 2 && s > 0) begin
        clk_en = 1'b0;
        s--;
      end else begin
        clk_en = 1'b1;
      end
    end
  endtask
  task sub(input logic [7:0] k, input logic x, input int stall);
    exec({5'b11110, x, k}, stall);
    c_m = k >= acc_m;
    dc_m = k[3:0] >= acc_m[3:0];
    acc_m = k - acc_m;
    z_m = acc_m == 8'h00;
    chk8(accumulator_reg, acc_m);
    chk1(borrow_inverse_bit, c_m);
    chk1(half_borrow_inverse, dc_m);
    chk1(result_null_flag, z_m);
    chk1(rf_we, 1'b0);
  endtask
  task rot(input logic left, input logic d, input logic [7:0] v);
    exec({5'b00110, left, d, 7'h15}, 0);
    rv = left ? {v[6:0], c_m} : {c_m, v[7:1]};
    c_m = left ? v[7] : v[0];
    if (!d) acc_m = rv;
    chk8(accumulator_reg, acc_m);
    chk1(rf_we, d);
    if (d) chk8(rf_wdata, rv);
    if (d) chk8({1'b0, rf_addr}, 8'h15);
    chk1(borrow_inverse_bit, c_m);
    chk1(half_borrow_inverse, dc_m);
    chk1(result_null_flag, z_m);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #10000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (19) @(negedge sys_clk);
    ld_en = 1'b1;
    @(negedge sys_clk);
    ld_en = 1'b0;
    chk8(accumulator_reg, 8'h00);
    chk1(power_down_flag_b, 1'b1);
    chk1(halted, 1'b0);
    rst_b = 1'b1;
    {acc_m, c_m, dc_m, z_m} = 11'h000;
    // Sign, zero and nibble borrow corners, plus a stalled cycle
    sub(8'h02, 1'b0, 0);
    sub(8'h02, 1'b1, 0);
    sub(8'h01, 1'b0, 3);
    sub(8'h00, 1'b0, 0);
    sub(8'hFF, 1'b0, 0);
    sub(8'h10, 1'b0, 0);
    sub(8'h08, 1'b0, 0);
    rot(1'b1, 1'b0, 8'hE6);
    rot(1'b0, 1'b1, 8'hE6);
    rot(1'b1, 1'b0, 8'hF3);
    rot(1'b1, 1'b1, 8'hF3);
    rot(1'b0, 1'b0, 8'hE7);
    exec(14'h0000, 0);
    chk8(accumulator_reg, acc_m);
    chk1(rf_we, 1'b0);
    exec(14'h0063, 0);
    instr_valid = 1'b0;
    chk1(power_down_flag_b, 1'b0);
    chk1(watchdog_expiry_flag_b, 1'b1);
    chk1(watchdog_clear, 1'b1);
    chk1(halted, 1'b1);
    chk1(osc_stop, 1'b1);
    chk8(accumulator_reg, acc_m);
    chk1(borrow_inverse_bit, c_m);
    chk1(half_borrow_inverse, dc_m);
    chk1(result_null_flag, z_m);
    @(negedge sys_clk);
    chk1(watchdog_clear, 1'b0);
    // Words offered while halted must be ignored
    instr = 14'h3C55;
    instr_valid = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk8(accumulator_reg, acc_m);
    chk1(phase_q1, 1'b0);
    instr_valid = 1'b0;
    wake_req = 1'b1;
    for (int i = 0; i < 10 && halted !== 1'b0; i++) @(negedge sys_clk);
    chk1(osc_stop, 1'b0);
    wake_req = 1'b0;
    sub(8'h33, 1'b1, 0);
    instr_valid = 1'b0;
    stop_test;
  end
endmodule
